// *** hdl/acu_pkg.sv ***
package acu_pkg;

    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_CONFIG   = 8'h04;
    localparam logic [7:0]  OFF_CEN_HIGH = 8'h08;
    localparam logic [7:0]  OFF_CEN_LOW  = 8'h0c;
    localparam logic [7:0]  OFF_STATUS   = 8'h10;
    localparam logic [7:0]  OFF_MASK_SET = 8'h14;
    localparam logic [7:0]  OFF_MASK_CLR = 8'h18;
    localparam logic [7:0]  OFF_MASK     = 8'h1c;
    localparam logic [7:0]  OFF_FLAG_CLR = 8'h20;

    // control register command bits
    localparam int          CTRL_EN      = 0;
    localparam int          CTRL_DIS     = 1;
    localparam int          CTRL_SEN     = 2;
    localparam int          CTRL_SDIS    = 3;

    // configuration register fields
    localparam int          CFG_KEY_LSB  = 0;
    localparam int          CFG_CYC_LSB  = 8;

    // status word bit positions
    localparam int          ST_IDLE      = 10;
    localparam int          ST_SETUP     = 9;
    localparam int          ST_EN        = 8;
    localparam int          FL_REMAP_ADDRESS_ERROR    = 7;
    localparam int          FL_MBERR     = 6;
    localparam int          FL_URBLK     = 5;
    localparam int          FL_UNLOCK_KEY_ERROR     = 4;
    localparam int          FL_UNLOCK_READ_ERROR    = 3;
    localparam int          FL_AFAIL     = 2;
    localparam int          FL_AOK       = 1;
    localparam int          FL_TMO       = 0;

    localparam logic [7:0]  ERR_FLAGS    = 8'hfc;
    localparam logic [15:0] RTR_HI_MIN   = 16'hfffc;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_HALF     = 16'h0000;
    localparam logic [5:0]  RST_CHAN     = 6'h00;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } acu_pb_req_t;

    typedef struct packed {
        logic        access;
        logic [5:0]  access_chan;
        logic        done;
        logic        pending;
        logic        mbus_err;
        logic        rtr_wr;
        logic [31:0] rtr_wdata;
        logic        ur_wr;
        logic [7:0]  ur_key;
        logic [5:0]  ur_chan;
        logic        ur_rd;
    } acu_chan_evt_t;

endpackage

// *** hdl/acu_regs.sv ***
`timescale 1ns/1ps
// Summary of operation
// R1 - high enable bit n enables channel n+32
// R2 - low enable bit n enables channel n
// R3 - idle bit set on start, cleared when done with none pending
// R4 - status bit 9 follows setup mode
// R5 - status bit 8 follows unit enable
// R6 - setup-time remap write outside top range flags
// R7 - master bus error response sets flag 6
// R8 - unlock with errors pending aborts, flag 5
// R9 - wrong unlock key sets flag 4
// R10 - reading unlock register sets flag 3
// R11 - locked or disabled channel access flags 2
// R12 - single access after unlock sets flag 1
// R13 - unlock expiry without access sets flag 0
// R14 - event flags hold until cleared by one
// R15 - mask set register ones set mask bits
// R16 - mask clear register ones clear bits
// R17 - mask one enables matching flag interrupt
// R18 - flag clear also withdraws pending interrupt
// R19 - unlock lasts configured cycles or one access
// R20 - interrupt when any flag and mask set
module acu_regs
(
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rstn,
    input  wire acu_pkg::acu_pb_req_t   i_pb_req,
    output logic [31:0]                 o_pb_rdata,
    input  wire acu_pkg::acu_chan_evt_t i_chan_evt,
    output logic [63:0]                 o_chan_enable,
    output logic                        o_unit_enabled,
    output logic                        o_setup_mode,
    output logic                        o_unlocked,
    output logic [5:0]                  o_unlocked_chan,
    output logic                        o_irq
);
    import acu_pkg::*;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [31:0] cen_low;
    logic [31:0] cen_high;
    logic [15:0] cfg;
    logic        unit_en;
    logic        setup;
    logic        busy;
    logic [7:0]  flags;
    logic [7:0]  irq_mask;
    logic        unlocked;
    logic [5:0]  ulk_chan;
    logic [7:0]  ulk_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire         wr_ctrl   = i_pb_req.wr & hit(i_pb_req.addr, OFF_CTRL);
    wire         wr_cfg    = i_pb_req.wr & hit(i_pb_req.addr, OFF_CONFIG);
    wire         wr_chigh  = i_pb_req.wr & hit(i_pb_req.addr, OFF_CEN_HIGH);
    wire         wr_clow   = i_pb_req.wr & hit(i_pb_req.addr, OFF_CEN_LOW);
    wire         wr_mset   = i_pb_req.wr & hit(i_pb_req.addr, OFF_MASK_SET);
    wire         wr_mclr   = i_pb_req.wr & hit(i_pb_req.addr, OFF_MASK_CLR);
    wire         wr_fclr   = i_pb_req.wr & hit(i_pb_req.addr, OFF_FLAG_CLR);
    wire [31:0]  wd        = i_pb_req.wdata;
    // control command bits act only in the cycle the control word is written
    wire         cmd_en    = wr_ctrl & wd[CTRL_EN];
    wire         cmd_dis   = wr_ctrl & wd[CTRL_DIS];
    wire         cmd_sen   = wr_ctrl & wd[CTRL_SEN];
    wire         cmd_sdis  = wr_ctrl & wd[CTRL_SDIS];
    wire [7:0]   mask_on   = wr_mset ? wd[7:0] : RST_BYTE;                 // R15
    wire [7:0]   mask_off  = wr_mclr ? wd[7:0] : RST_BYTE;                 // R16

    wire [7:0]   cfg_key   = cfg[CFG_KEY_LSB +: 8];
    wire [7:0]   cfg_cyc   = cfg[CFG_CYC_LSB +: 8];
    wire [63:0]  chan_en   = {cen_high, cen_low};  // R1 R2

    ////////////////////////////////////////////////////////////////////////////
    // unit events
    // an access can only hit the one unlocked channel, and only if it is enabled
    wire         acc_ok    = i_chan_evt.access & unlocked
                           & (i_chan_evt.access_chan == ulk_chan)
                           & chan_en[i_chan_evt.access_chan];
    wire         acc_fail  = i_chan_evt.access & ~acc_ok;                 // R11
    wire         expire    = unlocked & ~i_chan_evt.access
                           & (ulk_cnt == RST_BYTE);                        // R13
    wire         rtr_bad   = setup & i_chan_evt.rtr_wr
                           & (i_chan_evt.rtr_wdata[31:16] < RTR_HI_MIN);   // R6
    // expiry and success are not errors, so they never block an unlock
    wire         err_pending = |(flags & ERR_FLAGS);
    wire         key_match   = (i_chan_evt.ur_key == cfg_key);
    wire         ur_blk    = i_chan_evt.ur_wr & err_pending;               // R8
    wire         ur_badkey = i_chan_evt.ur_wr & ~ur_blk
                           & ~key_match;                                   // R9
    wire         ur_good   = i_chan_evt.ur_wr & ~ur_blk & ~ur_badkey;

    wire [7:0]   flag_set;
    assign flag_set[FL_REMAP_ADDRESS_ERROR] = rtr_bad;                                  // R6
    assign flag_set[FL_MBERR]  = i_chan_evt.mbus_err;                      // R7
    assign flag_set[FL_URBLK]  = ur_blk;                                   // R8
    assign flag_set[FL_UNLOCK_KEY_ERROR]  = ur_badkey;                                // R9
    assign flag_set[FL_UNLOCK_READ_ERROR] = i_chan_evt.ur_rd;                         // R10
    assign flag_set[FL_AFAIL]  = acc_fail;                                 // R11
    assign flag_set[FL_AOK]    = acc_ok;                                   // R12
    assign flag_set[FL_TMO]    = expire;                                   // R13

    // a new event in the clearing cycle survives the clear
    wire [7:0]   flag_clr   = wr_fclr ? wd[7:0] : RST_BYTE;
    wire [7:0]   next_flags = (flags & ~flag_clr) | flag_set;              // R14 R18
    wire [7:0]   next_mask  = (irq_mask | mask_on) & ~mask_off;            // R15 R16

    // enable wins over disable when both are written at once
    wire         next_en    = cmd_en  ? 1'b1
                            : cmd_dis ? 1'b0 : unit_en;                    // R5
    wire         next_setup = cmd_sen  ? 1'b1
                            : cmd_sdis ? 1'b0 : setup;                     // R4
    wire         next_busy  = i_chan_evt.access ? 1'b1
                            : (i_chan_evt.done & ~i_chan_evt.pending)
                              ? 1'b0 : busy;                               // R3

    // the window ends on the first access, whatever its outcome
    wire         next_unlocked = ur_good ? 1'b1
                               : (i_chan_evt.access | expire) ? 1'b0
                               : unlocked;                                 // R19
    wire         cnt_run       = unlocked & (ulk_cnt != RST_BYTE);
    wire [7:0]   next_cnt      = ur_good ? cfg_cyc
                               : cnt_run ? ulk_cnt - 8'h01
                               : ulk_cnt;                                  // R19

    ////////////////////////////////////////////////////////////////////////////
    // read mux; write-only and unmapped offsets read as zero
    wire         sel_chigh   = hit(i_pb_req.addr, OFF_CEN_HIGH);
    wire         sel_clow    = hit(i_pb_req.addr, OFF_CEN_LOW);
    wire         sel_status  = hit(i_pb_req.addr, OFF_STATUS);
    wire         sel_mask    = hit(i_pb_req.addr, OFF_MASK);
    wire [31:0]  status_word = {21'h0, busy, setup, unit_en, flags};       // R3 R4 R5
    wire [31:0]  rd_mux      = sel_chigh  ? cen_high    :
                               sel_clow   ? cen_low     :
                               sel_status ? status_word :
                               sel_mask   ? {24'h000000, irq_mask} : RST_WORD;

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cen_low <= RST_WORD;
        else if (wr_clow)
            cen_low <= wd;                                                 // R2
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cen_high <= RST_WORD;
        else if (wr_chigh)
            cen_high <= wd;                                                // R1
    end

    // only key and cycle count are stored; the upper half has no storage
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cfg <= RST_HALF;
        else if (wr_cfg)
            cfg <= wd[15:0];
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            irq_mask <= RST_BYTE;
        else
            irq_mask <= next_mask;                                         // R17
    end

    ////////////////////////////////////////////////////////////////////////////
    // unit modes and channel activity
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            unit_en <= 1'b0;
        else
            unit_en <= next_en;                                            // R5
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            setup <= 1'b0;
        else
            setup <= next_setup;                                           // R4
    end

    // an access in the same cycle as a completion keeps the unit busy
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            busy <= 1'b0;
        else
            busy <= next_busy;                                             // R3
    end

    // sticky event flags
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            flags <= RST_BYTE;
        else
            flags <= next_flags;                                           // R14
    end

    ////////////////////////////////////////////////////////////////////////////
    // unlock window
    // a fresh unlock restarts the window even when one is already open
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            unlocked <= 1'b0;
        else
            unlocked <= next_unlocked;                                     // R19
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            ulk_cnt <= RST_BYTE;
        else
            ulk_cnt <= next_cnt;                                           // R19
    end

    // the channel number is captured only by an accepted unlock
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            ulk_chan <= RST_CHAN;
        else if (ur_good)
            ulk_chan <= i_chan_evt.ur_chan;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all registered
    // read data drops back to zero between reads
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_pb_rdata <= RST_WORD;
        else
            o_pb_rdata <= i_pb_req.rd ? rd_mux : RST_WORD;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_chan_enable <= {RST_WORD, RST_WORD};
        else
            o_chan_enable <= chan_en;                                      // R1 R2
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_unit_enabled <= 1'b0;
        else
            o_unit_enabled <= unit_en;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_setup_mode <= 1'b0;
        else
            o_setup_mode <= setup;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_unlocked <= 1'b0;
        else
            o_unlocked <= unlocked;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_unlocked_chan <= RST_CHAN;
        else
            o_unlocked_chan <= ulk_chan;
    end

    // uses current state so a clear withdraws the request two cycles after the write
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_irq <= 1'b0;
        else
            o_irq <= |(flags & irq_mask);                                  // R17 R18 R20
    end

endmodule // acu_regs

// *** testbench/acu_evt_model.sv ***
`timescale 1ns/1ps
module acu_evt_model
(
    input  wire logic              i_sys_clk,
    output acu_pkg::acu_chan_evt_t o_evt
);
    import acu_pkg::*;
    acu_chan_evt_t held;
    logic          act  = 1'b0;
    logic [31:0]   junk = 32'h5a5a_0f0f;
    // data fields move every cycle outside a strobe so stale values cannot pass
    assign o_evt = act ? held : '{rtr_wdata:junk, ur_key:junk[7:0], ur_chan:junk[13:8],
                                  access_chan:junk[21:16], default:'0};
    always @(posedge i_sys_clk) junk <= ~{junk[30:0], junk[31]};
    task automatic pulse(input acu_chan_evt_t e);
        @(posedge i_sys_clk);
        held <= e;
        act  <= 1'b1;
        @(posedge i_sys_clk);
        act  <= 1'b0;
    endtask
endmodule // acu_evt_model

// *** testbench/acu_regs_bench.sv ***
`timescale 1ns/1ps
module acu_regs_bench;
    import acu_pkg::*;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
    logic          clk = 1'b0;
    logic          rstn = 1'b0;
    acu_pb_req_t   req = '0;
    acu_chan_evt_t evt;
    logic [31:0]   rdata, w;
    logic [63:0]   cen;
    logic [5:0]    uch;
    logic [7:0]    key;
    logic          en, sm, ul, irq;
    int            fail_count = 0;
    int            n_tests = 0;
    int            cyc = 0;
    always #2 clk = ~clk;
    acu_evt_model i_far (.i_sys_clk(clk), .o_evt(evt));
    acu_regs i_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_pb_req(req), .o_pb_rdata(rdata),
        .i_chan_evt(evt), .o_chan_enable(cen), .o_unit_enabled(en), .o_setup_mode(sm),
        .o_unlocked(ul), .o_unlocked_chan(uch), .o_irq(irq));
    function automatic logic [31:0] f(input int b);
        return 32'h1 << b;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{wr:1'b1, addr:a, wdata:d, default:'0};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        req <= '{rd:1'b1, addr:a, default:'0};
        @(posedge clk);
        req <= '0;
        #1;
        `CHK(rdata, e)
    endtask
    // status check, then every flag is cleared for the next step
    task automatic st(input logic [31:0] e);
        rd(OFF_STATUS, e);
        wr(OFF_FLAG_CLR, 32'hff);
    endtask
    task automatic unl(input logic [7:0] k);
        i_far.pulse('{ur_wr:1'b1, ur_key:k, ur_chan:6'd3, default:'0});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            end_of_test();
        end
    end
    initial
    begin
        w = $urandom(37);
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a < 'h28; a += 4) rd(8'(a), 32'h0);
        repeat (4)
        begin
            w = $urandom();
            wr(OFF_CEN_LOW, w);
            rd(OFF_CEN_LOW, w);
            wr(OFF_CEN_HIGH, ~w);
            rd(OFF_CEN_HIGH, ~w);
            `CHK(cen, {~w, w})
        end
        wr(OFF_CEN_LOW, 32'h8);
        wr(OFF_CEN_HIGH, 32'h0);
        wr(OFF_CTRL, 32'hf);
        i_far.pulse('{rtr_wr:1'b1, rtr_wdata:32'hfffb_ffff, default:'0});
        i_far.pulse('{rtr_wr:1'b1, rtr_wdata:32'hfffc_0010, default:'0});
        st(f(FL_REMAP_ADDRESS_ERROR) | f(ST_EN) | f(ST_SETUP));
        wr(OFF_CTRL, 32'h8);
        i_far.pulse('{rtr_wr:1'b1, rtr_wdata:32'h1234_0000, default:'0});
        st(f(ST_EN));
        `CHK({en, sm}, 2'b10)
        wr(OFF_MASK_SET, 32'hff);
        wr(OFF_MASK_SET, 32'h0);
        wr(OFF_MASK_CLR, 32'h0f);
        rd(OFF_MASK, 32'hf0);
        i_far.pulse('{ur_rd:1'b1, default:'0});
        rd(OFF_STATUS, f(FL_UNLOCK_READ_ERROR) | f(ST_EN));
        tick(2);
        `CHK(irq, 1'b0)
        wr(OFF_MASK_SET, f(FL_UNLOCK_READ_ERROR));
        tick(2);
        `CHK(irq, 1'b1)
        wr(OFF_MASK_CLR, 32'hff);
        tick(2);
        `CHK(irq, 1'b0)
        wr(OFF_MASK_SET, f(FL_UNLOCK_READ_ERROR));
        st(f(FL_UNLOCK_READ_ERROR) | f(ST_EN));
        tick(2);
        `CHK(irq, 1'b0)
        key = 8'($urandom());
        wr(OFF_CONFIG, {16'h0, 8'd5, key});
        unl(key);
        tick(1);
        `CHK({ul, uch}, {1'b1, 6'd3})
        i_far.pulse('{access:1'b1, access_chan:6'd3, default:'0});
        i_far.pulse('{done:1'b1, default:'0});
        st(f(FL_AOK) | f(ST_EN));
        `CHK(ul, 1'b0)
        unl(key);
        tick(5);
        `CHK(ul, 1'b1)
        tick(3);
        `CHK(ul, 1'b0)
        st(f(FL_TMO) | f(ST_EN));
        unl(~key);
        unl(key);
        tick(1);
        `CHK(ul, 1'b0)
        st(f(FL_UNLOCK_KEY_ERROR) | f(FL_URBLK) | f(ST_EN));
        i_far.pulse('{access:1'b1, access_chan:6'd40, default:'0});
        st(f(FL_AFAIL) | f(ST_IDLE) | f(ST_EN));
        i_far.pulse('{done:1'b1, pending:1'b1, default:'0});
        rd(OFF_STATUS, f(ST_IDLE) | f(ST_EN));
        i_far.pulse('{done:1'b1, default:'0});
        i_far.pulse('{mbus_err:1'b1, default:'0});
        st(f(FL_MBERR) | f(ST_EN));
        end_of_test();
    end
endmodule // acu_regs_bench

// *** testbench/acu_regs_properties.sv ***
`timescale 1ns/1ps
module acu_regs_properties
(
    input wire logic                   i_sys_clk,
    input wire logic                   i_rstn,
    input wire acu_pkg::acu_pb_req_t   i_pb_req,
    input wire logic [31:0]            o_pb_rdata,
    input wire acu_pkg::acu_chan_evt_t i_chan_evt,
    input wire logic [63:0]            o_chan_enable,
    input wire logic                   o_unit_enabled,
    input wire logic                   o_setup_mode,
    input wire logic                   o_unlocked,
    input wire logic [5:0]             o_unlocked_chan,
    input wire logic                   o_irq
);
    import acu_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    logic w_ctrl, w_mclr, w_fclr, quiet;
    assign w_ctrl = i_pb_req.wr && i_pb_req.addr == OFF_CTRL;
    assign w_mclr = i_pb_req.wr && i_pb_req.addr == OFF_MASK_CLR && i_pb_req.wdata[7:0] == 8'hff;
    assign w_fclr = i_pb_req.wr && i_pb_req.addr == OFF_FLAG_CLR && i_pb_req.wdata[7:0] == 8'hff;
    // the unlock timer can set a flag with no input event, so a fresh unlock excludes the check
    assign quiet = !(i_chan_evt.access | i_chan_evt.mbus_err | i_chan_evt.rtr_wr
                     | i_chan_evt.ur_wr | i_chan_evt.ur_rd | o_unlocked);
    sequence st_rd;
        i_pb_req.rd && i_pb_req.addr == OFF_STATUS;
    endsequence
    // the flag must survive the cycle between the event and the read
    sequence ur_rd_seen;
        i_chan_evt.ur_rd ##1 !(i_pb_req.wr && i_pb_req.addr == OFF_FLAG_CLR) ##1 st_rd;
    endsequence
    sequence access_seen;
        i_chan_evt.access ##1 !i_chan_evt.done ##1 st_rd;
    endsequence
    rdata_idle_a: assert property (!i_pb_req.rd |=> o_pb_rdata == 32'h0)
        else $error("read data not zero");
    unlock_read_a: assert property (ur_rd_seen |=> o_pb_rdata[FL_UNLOCK_READ_ERROR])
        else $error("unlock read flag missing");
    idle_set_a: assert property (access_seen |=> o_pb_rdata[ST_IDLE])
        else $error("idle bit missing");
    cen_low_a: assert property (i_pb_req.wr && i_pb_req.addr == OFF_CEN_LOW
        |=> ##1 o_chan_enable[31:0] == $past(i_pb_req.wdata, 2)) else $error("low enable");
    cen_high_a: assert property (i_pb_req.wr && i_pb_req.addr == OFF_CEN_HIGH
        |=> ##1 o_chan_enable[63:32] == $past(i_pb_req.wdata, 2)) else $error("high enable");
    setup_enter_a: assert property (w_ctrl && i_pb_req.wdata[CTRL_SEN] |=> ##1 o_setup_mode)
        else $error("setup mode missing");
    unit_enable_a: assert property (w_ctrl && i_pb_req.wdata[CTRL_EN] |=> ##1 o_unit_enabled)
        else $error("unit enable missing");
    mask_off_a: assert property (w_mclr |=> ##1 !o_irq)
        else $error("irq with mask cleared");
    flag_clear_a: assert property (w_fclr && quiet && !$past(i_chan_evt.ur_wr) |=> ##1 !o_irq)
        else $error("irq after flag clear");
endmodule // acu_regs_properties
bind acu_regs acu_regs_properties i_props (.i_sys_clk, .i_rstn, .i_pb_req, .o_pb_rdata,
    .i_chan_evt, .o_chan_enable, .o_unit_enabled, .o_setup_mode, .o_unlocked,
    .o_unlocked_chan, .o_irq);
